// ===== core/aeskoc_core.sv
// AES accelerator core: register file, key byte ordering, round engine and sequencing.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module aeskoc_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [aeskoc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  logic [2:0] mode;
  logic [5:0] endian;
  logic [31:0] key_reg [8];
  logic [31:0] text_reg [4];
  logic [31:0] kw [aeskoc_pkg::KW_DEPTH];
  logic [31:0] next_kw [aeskoc_pkg::KW_DEPTH];
  logic [31:0] key_map [8];
  logic [31:0] out_text [4];
  logic [127:0] st, next_st, in_state;
  aeskoc_pkg::aeskoc_state_e state;
  logic idle, is_dec, accept, finish;
  logic [3:0] nk, nr, rnd;
  logic [6:0] cnt, need;
  logic [4:0] lat, busy_len;
  logic [2:0] key_idx;
  logic [1:0] text_idx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction : xt

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction : gmul

  // Inverse by a^254 keeps the design free of two 256-entry tables, at a cost in logic depth.
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = a;
    for (int k = 1; k < 8; k++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
  endfunction : sbox

  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05);
  endfunction : isbox

  function automatic logic [31:0] bswap(input logic [31:0] w, input logic rev);
    return rev ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : bswap

  function automatic logic [31:0] sub_word(input logic [31:0] w);
    return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction : sub_word

  function automatic logic [7:0] rcon(input int n);
    logic [7:0] r;
    r = 8'h01;
    for (int j = 1; j < 10; j++) begin
      if (j < n) r = xt(r);
    end
    return r;
  endfunction : rcon

  function automatic logic [127:0] mix(input logic [127:0] s, input logic [31:0] cf);
    logic [127:0] m;
    m = s;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        m[127-8*(4*c+r) -: 8] = gmul(s[127-8*(4*c+r) -: 8], cf[31:24])
          ^ gmul(s[127-8*(4*c+(r+1)%4) -: 8], cf[23:16])
          ^ gmul(s[127-8*(4*c+(r+2)%4) -: 8], cf[15:8])
          ^ gmul(s[127-8*(4*c+(r+3)%4) -: 8], cf[7:0]);
      end
    end
    return m;
  endfunction : mix

  function automatic logic [127:0] rkey(input logic [3:0] r);
    return {kw[4*r], kw[4*r+1], kw[4*r+2], kw[4*r+3]};
  endfunction : rkey

  function automatic logic [127:0] enc_round(input logic [127:0] s, input logic [127:0] rk,
                                             input logic last);
    logic [127:0] t;
    t = s;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[127-8*(4*c+r) -: 8] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
      end
    end
    if (!last) t = mix(t, 32'h02030101);
    return t ^ rk;
  endfunction : enc_round

  // Decryption folds the leading key addition into the first step and the final one into the last, so only Nr steps are needed.
  function automatic logic [127:0] dec_step(input logic [127:0] s, input logic [127:0] rk,
                                            input logic [127:0] rk0, input logic first,
                                            input logic last);
    logic [127:0] t;
    logic [127:0] u;
    t = s ^ rk;
    if (!first) t = mix(t, 32'h0E0B0D09);
    u = t;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        u[127-8*(4*c+r) -: 8] = isbox(t[127-8*(4*((c-r+4)%4)+r) -: 8]);
      end
    end
    return last ? u ^ rk0 : u;
  endfunction : dec_step

  assign key_idx = 3'((addr - aeskoc_pkg::OFF_KEY0) >> 2);
  assign text_idx = 2'((addr - aeskoc_pkg::OFF_TEXT0) >> 2);
  assign need = 7'({nr, 2'b00} + 7'h04);
  assign accept = wr && addr == aeskoc_pkg::OFF_START && wdata[0]
    && state == aeskoc_pkg::ST_IDLE && mode[1:0] != 2'b11;
  assign finish = state == aeskoc_pkg::ST_RUN
    && 5'(lat + 5'h01) == (is_dec ? aeskoc_pkg::DEC_CYCLES : aeskoc_pkg::ENC_CYCLES);

  // Words past the key length read as zero so a stale longer key cannot leak in.
  function automatic logic word_unused(input int j, input logic [2:0] m);
    return j >= 4 + 2 * int'(m[1:0]);
  endfunction : word_unused

  always_comb begin
    for (int j = 0; j < 8; j++) begin
      key_map[j] = word_unused(j, mode) ? 32'h0 : bswap(key_reg[endian[aeskoc_pkg::KEY_WORD_BIT]
        ? j : (4 + 2 * int'(mode[1:0]) + 7 - j) % 8],
        endian[aeskoc_pkg::KEY_BYTE_BIT]);
    end
    for (int c = 0; c < 4; c++) begin
      in_state[127-32*c -: 32] = bswap(text_reg[endian[aeskoc_pkg::IN_WORD_BIT] ? c : 3 - c],
        endian[aeskoc_pkg::IN_BYTE_BIT]);
      out_text[c] = bswap(next_st[127-32*(endian[aeskoc_pkg::OUT_WORD_BIT] ? c : 3 - c) -: 32],
        endian[aeskoc_pkg::OUT_BYTE_BIT]);
    end
  end

  // Eight expanded-key words per cycle lets encryption rounds trail the schedule closely.
  always_comb begin
    logic [31:0] tmp;
    int i;
    tmp = 32'h0;
    i = 0;
    next_kw = kw;
    for (int k = 0; k < 8; k++) begin
      i = int'(cnt) + k;
      if (i >= int'(nk) && i < aeskoc_pkg::KW_DEPTH) begin
        tmp = next_kw[i-1];
        if (i % int'(nk) == 0) tmp = sub_word({tmp[23:0], tmp[31:24]}) ^ {rcon(i / int'(nk)), 24'h0};
        else if (nk == 4'h8 && i % 8 == 4) tmp = sub_word(tmp);
        next_kw[i] = next_kw[i - int'(nk)] ^ tmp;
      end
    end
  end

  always_comb begin
    next_st = st;
    if (state == aeskoc_pkg::ST_RUN) begin
      if (is_dec) begin
        if (cnt >= need && rnd != 4'h0) next_st = dec_step(st, rkey(rnd), rkey(4'h0), rnd == nr,
          rnd == 4'h1);
      end else if (rnd <= nr && cnt >= 7'({rnd, 2'b00} + 7'h04)) begin
        next_st = enc_round(st, rkey(rnd), rnd == nr);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= aeskoc_pkg::MODE_RST;
      endian <= aeskoc_pkg::ENDIAN_RST;
      for (int j = 0; j < 8; j++) key_reg[j] <= aeskoc_pkg::WORD_RST;
    end else if (wr && idle) begin
      if (addr == aeskoc_pkg::OFF_MODE) mode <= wdata[2:0];
      if (addr == aeskoc_pkg::OFF_ENDIAN) endian <= wdata[5:0];
      if (addr >= aeskoc_pkg::OFF_KEY0 && addr < aeskoc_pkg::OFF_TEXT0 && addr[1:0] == 2'b00) begin
        key_reg[key_idx] <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int j = 0; j < 4; j++) text_reg[j] <= aeskoc_pkg::WORD_RST;
    end else if (finish) begin
      for (int j = 0; j < 4; j++) text_reg[j] <= out_text[j];
    end else if (wr && idle && addr >= aeskoc_pkg::OFF_TEXT0 && addr < aeskoc_pkg::OFF_ENDIAN
                 && addr[1:0] == 2'b00) begin
      text_reg[text_idx] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= aeskoc_pkg::ST_IDLE;
      idle <= 1'b1;
      is_dec <= 1'b0;
      nk <= 4'h4;
      nr <= 4'hA;
      cnt <= 7'h00;
      rnd <= 4'h0;
      lat <= 5'h00;
    end else begin
      unique case (state)
        aeskoc_pkg::ST_IDLE: begin
          if (accept) begin
            state <= aeskoc_pkg::ST_RUN;
            idle <= 1'b0;
            is_dec <= mode[2];
            nk <= 4'(4'h4 + {mode[1:0], 1'b0});
            nr <= 4'(4'hA + {mode[1:0], 1'b0});
            cnt <= 7'(4'h4 + {mode[1:0], 1'b0});
            rnd <= mode[2] ? 4'(4'hA + {mode[1:0], 1'b0}) : 4'h1;
            lat <= 5'h00;
          end
        end
        aeskoc_pkg::ST_RUN: begin
          lat <= 5'(lat + 5'h01);
          if (cnt < need) cnt <= 7'(cnt + 7'h08);
          if (next_st != st || (is_dec ? (cnt >= need && rnd != 4'h0)
              : (rnd <= nr && cnt >= 7'({rnd, 2'b00} + 7'h04)))) begin
            rnd <= is_dec ? 4'(rnd - 4'h1) : 4'(rnd + 4'h1);
          end
          if (finish) begin
            state <= aeskoc_pkg::ST_IDLE;
            idle <= 1'b1;
          end
        end
      endcase
    end
  end

  // Datapath storage needs no reset; it is always loaded before it is used.
  always_ff @(posedge clk) begin
    if (accept) begin
      for (int j = 0; j < 8; j++) kw[j] <= key_map[j];
      st <= mode[2] ? in_state : in_state ^ {key_map[0], key_map[1], key_map[2], key_map[3]};
    end else begin
      if (state == aeskoc_pkg::ST_RUN && cnt < need) kw <= next_kw;
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (!rd) begin
      rdata <= 32'h0;
    end else if (addr == aeskoc_pkg::OFF_IDLE) begin
      rdata <= {31'h0, idle};
    end else if (addr == aeskoc_pkg::OFF_MODE) begin
      rdata <= {29'h0, mode};
    end else if (addr == aeskoc_pkg::OFF_ENDIAN) begin
      rdata <= {26'h0, endian};
    end else if (addr >= aeskoc_pkg::OFF_KEY0 && addr < aeskoc_pkg::OFF_TEXT0 && addr[1:0] == 2'b00) begin
      rdata <= key_reg[key_idx];
    end else if (addr >= aeskoc_pkg::OFF_TEXT0 && addr < aeskoc_pkg::OFF_ENDIAN && addr[1:0] == 2'b00) begin
      rdata <= text_reg[text_idx];
    end else begin
      rdata <= 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || idle) busy_len <= 5'h00;
    else busy_len <= 5'(busy_len + 5'h01);
  end

  sequence s_launch;
    accept;
  endsequence
  sequence s_busy_two;
    !idle ##1 !idle;
  endsequence

  a_start_launches: assert property (s_launch |=> s_busy_two)
    else $error("start did not launch");
  a_busy_blocks_start: assert property (wr && addr == aeskoc_pkg::OFF_START && !idle && !finish
    |=> !idle && $stable(is_dec) && lat != 5'h00)
    else $error("start during busy disturbed operation");
  a_idle_matches_run: assert property ((state == aeskoc_pkg::ST_RUN) == !idle)
    else $error("idle flag disagrees with engine");
  a_enc_latency: assert property ($rose(idle) && !is_dec |-> busy_len == 5'h0E)
    else $error("encrypt latency wrong");
  a_dec_latency: assert property ($rose(idle) && is_dec |-> busy_len == 5'h15)
    else $error("decrypt latency wrong");
  a_cfg_kept: assert property ($rose(idle) |-> $stable(mode) && $stable(endian)
    && $stable(key_reg[0]) && $stable(key_reg[7]))
    else $error("completion altered configuration");
  a_key128_order: assert property (accept && mode == aeskoc_pkg::MODE_ENC128 && endian[1:0] == 2'b00
    |=> kw[0] == $past(key_reg[3]) && kw[3] == $past(key_reg[0]))
    else $error("128-bit key word order wrong");
  a_key192_order: assert property (accept && mode[1:0] == 2'b01 && endian[1:0] == 2'b10
    |=> kw[0] == $past(key_reg[0]) && kw[5] == $past(key_reg[5]))
    else $error("192-bit key word order wrong");
  a_key256_order: assert property (accept && mode == aeskoc_pkg::MODE_ENC256 && endian[1:0] == 2'b00
    |=> kw[0] == $past(key_reg[7]) && kw[7] == $past(key_reg[0]))
    else $error("256-bit key word order wrong");
  a_key_byte_rev: assert property (accept && mode == aeskoc_pkg::MODE_ENC128 && endian[1:0] == 2'b11
    |=> kw[0] == {$past(key_reg[0][7:0]), $past(key_reg[0][15:8]), $past(key_reg[0][23:16]),
    $past(key_reg[0][31:24])})
    else $error("key byte reversal wrong");
  a_bad_mode_held: assert property (wr && addr == aeskoc_pkg::OFF_START && wdata[0] && idle
    && mode[1:0] == 2'b11 |=> idle)
    else $error("illegal mode launched");
  a_text_busy_hold: assert property (!idle ##1 !idle |-> $stable(text_reg[0]))
    else $error("text changed mid operation");
endmodule : aeskoc_core

// ===== core/aeskoc_pkg.sv
// Shared constants for the AES key-order and operation-control block.
package aeskoc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_IDLE = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_KEY0 = 8'h10;
  localparam logic [7:0] OFF_TEXT0 = 8'h30;
  localparam logic [7:0] OFF_ENDIAN = 8'h40;
  localparam logic [2:0] MODE_ENC128 = 3'h0;
  localparam logic [2:0] MODE_ENC192 = 3'h1;
  localparam logic [2:0] MODE_ENC256 = 3'h2;
  localparam logic [2:0] MODE_DEC128 = 3'h4;
  localparam logic [2:0] MODE_DEC192 = 3'h5;
  localparam logic [2:0] MODE_DEC256 = 3'h6;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [5:0] ENDIAN_RST = 6'h00;
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam int KEY_BYTE_BIT = 0;
  localparam int KEY_WORD_BIT = 1;
  localparam int IN_BYTE_BIT = 2;
  localparam int IN_WORD_BIT = 3;
  localparam int OUT_BYTE_BIT = 4;
  localparam int OUT_WORD_BIT = 5;
  localparam logic [4:0] ENC_CYCLES = 5'h0E;
  localparam logic [4:0] DEC_CYCLES = 5'h15;
  localparam int KW_DEPTH = 64;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } aeskoc_state_e;
endpackage : aeskoc_pkg

// ===== testbench/aes_key_order_and_op_control_test.sv
// Self-checking testbench for the AES key-order and operation-control block.
`timescale 1ns/10ps
module aes_key_order_and_op_control_test;
  localparam int LIMIT = 10000;
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [31:0] d;
  int errors;
  int checks;
  int cycles;
  logic [127:0] ct_tab [3];
  logic [5:0] cfgs [4];
  logic [7:0] zaddr [5];

  initial clk = 1'b0;
  always #5 clk = ~clk;

  aeskoc_core u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  aeskoc_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  function automatic logic [31:0] bswap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : bswap

  function automatic int widx(input logic wbit, input int n, input int i);
    return wbit ? i : n - 1 - i;
  endfunction : widx

  function automatic logic [31:0] kword(input int i);
    return {8'(4 * i), 8'(4 * i + 1), 8'(4 * i + 2), 8'(4 * i + 3)};
  endfunction : kword

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Keys are skipped when unchanged, as a back-to-back sequence allows.
  task automatic run_op(input logic [2:0] mode, input logic [5:0] cfg, input logic [127:0] tin,
      input logic [127:0] tout, input bit keys, input bit dbl);
    int nk;
    int n;
    int lo;
    int hi;
    logic [31:0] v;
    nk = 4 + 2 * int'(mode[1:0]);
    lo = mode[2] ? 21 : 11;
    hi = mode[2] ? 22 : 15;
    u_host.bus_write(aeskoc_pkg::OFF_ENDIAN, {26'h0, cfg});
    u_host.bus_write(aeskoc_pkg::OFF_MODE, {29'h0, mode});
    if (keys) begin
      for (int i = 0; i < nk; i++) begin
        v = cfg[0] ? bswap(kword(i)) : kword(i);
        u_host.bus_write(aeskoc_pkg::OFF_KEY0 + 8'(4 * widx(cfg[1], nk, i)), v);
      end
    end
    for (int i = 0; i < 4; i++) begin
      v = cfg[2] ? bswap(tin[127 - 32 * i -: 32]) : tin[127 - 32 * i -: 32];
      u_host.bus_write(aeskoc_pkg::OFF_TEXT0 + 8'(4 * widx(cfg[3], 4, i)), v);
    end
    u_host.bus_write(aeskoc_pkg::OFF_START, 32'h1);
    if (dbl) u_host.bus_write(aeskoc_pkg::OFF_START, 32'h1);
    u_host.poll_idle(n);
    n += dbl ? 2 : 0;
    check("latency", 32'(n >= lo && n <= hi), 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = cfg[4] ? bswap(tout[127 - 32 * i -: 32]) : tout[127 - 32 * i -: 32];
      u_host.bus_read(aeskoc_pkg::OFF_TEXT0 + 8'(4 * widx(cfg[5], 4, i)), d);
      check("text", d, v);
    end
    u_host.bus_read(aeskoc_pkg::OFF_MODE, d);
    check("mode kept", d, {29'h0, mode});
    u_host.bus_read(aeskoc_pkg::OFF_ENDIAN, d);
    check("order kept", d, {26'h0, cfg});
    u_host.bus_read(aeskoc_pkg::OFF_KEY0 + 8'(4 * widx(cfg[1], nk, 0)), d);
    check("key kept", d, cfg[0] ? bswap(kword(0)) : kword(0));
    $display("Test mode %0d order %h done", mode, cfg);
  endtask : run_op

  // A hung poll or bus loop must still end the run with a verdict.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    ct_tab[0] = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    ct_tab[1] = 128'hDDA97CA4864CDFE06EAF70A0EC0D7191;
    ct_tab[2] = 128'h8EA2B7CA516745BFEAFC49904B496089;
    cfgs = '{6'h00, 6'h3F, 6'h15, 6'h2A};
    zaddr = '{aeskoc_pkg::OFF_MODE, aeskoc_pkg::OFF_ENDIAN, aeskoc_pkg::OFF_KEY0,
      aeskoc_pkg::OFF_TEXT0, 8'h4C};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (zaddr[i]) begin
      u_host.bus_read(zaddr[i], d);
      check("reset value", d, 32'h0);
    end
    u_host.bus_read(aeskoc_pkg::OFF_IDLE, d);
    check("idle at reset", d, 32'h1);
    $display("Test reset values done");
    foreach (cfgs[i]) run_op(aeskoc_pkg::MODE_ENC128, cfgs[i], PT, ct_tab[0], 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_ENC192, 6'h00, PT, ct_tab[1], 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_ENC192, 6'h2A, PT, ct_tab[1], 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_ENC256, 6'h00, PT, ct_tab[2], 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_ENC256, 6'h15, PT, ct_tab[2], 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_DEC256, 6'h15, ct_tab[2], PT, 1'b0, 1'b0);
    run_op(aeskoc_pkg::MODE_DEC192, 6'h00, ct_tab[1], PT, 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_DEC128, 6'h3F, ct_tab[0], PT, 1'b1, 1'b0);
    run_op(aeskoc_pkg::MODE_ENC128, 6'h00, PT, ct_tab[0], 1'b1, 1'b1);
    // An unused mode code must not start anything nor disturb the last result.
    u_host.bus_write(aeskoc_pkg::OFF_MODE, 32'h3);
    u_host.bus_write(aeskoc_pkg::OFF_START, 32'h1);
    u_host.bus_read(aeskoc_pkg::OFF_IDLE, d);
    check("idle after refused start", d, 32'h1);
    u_host.bus_read(aeskoc_pkg::OFF_TEXT0 + 8'hC, d);
    check("text after refused start", d, ct_tab[0][127:96]);
    $display("Test refused start done");
    print_verdict();
  end
endmodule : aes_key_order_and_op_control_test

// ===== testbench/aeskoc_host.sv
// Processor-side bus master that programs and polls the accelerator.
`timescale 1ns/10ps
module aeskoc_host (
  input wire logic clk,
  output logic [aeskoc_pkg::ADDR_W-1:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write strobe; the slave never stalls, so no wait is needed.
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_read

  // Reads idle every cycle and counts the busy readings, called straight after a start.
  task automatic poll_idle(output int n);
    addr <= aeskoc_pkg::OFF_IDLE;
    rd <= 1'b1;
    n = 0;
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (rdata[0] === 1'b1) break;
      n++;
    end
    @(posedge clk);
    rd <= 1'b0;
  endtask : poll_idle
endmodule : aeskoc_host
